// File: psc_ctrl.sv
// host-side controller driving the pins of an asynchronous pseudo-static ram
// What this block does
// - sequences chip select, output enable, write strobe
// - page reads: change only low three bits
// - lane enables select bytes on read and write
// - controller releases data lines during reads
// - every cycle is full length except page reads in an open page, which use the page cycle
// - contents lost after deep standby; flagged
// - hold power-down select 30 us after power
// - write ends on strobe rise; data held then
`timescale 1ns/1ps
`include "psc_map.svh"
`default_nettype none
module psc_ctrl #(
  parameter int CHP_CYC = `PSC_CHP_CYC,
  parameter int DPD_CYC = `PSC_DPD_CYC,
  parameter int CH_CYC  = `PSC_CH_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire logic                    req_write,
  input  wire logic [`PSC_ADDR_W-1:0]  req_addr,
  input  wire logic [`PSC_DATA_W-1:0]  req_wdata,
  input  wire logic [1:0]              req_lanes,
  input  wire logic                    req_page,
  input  wire logic                    dpd_req,
  input  wire logic                    wake_req,
  output logic                         rsp_valid,
  output logic [`PSC_DATA_W-1:0]       rsp_rdata,
  output logic                         data_lost,
  output logic                         in_dpd,
  output logic [`PSC_ADDR_W-1:0]       word_address,
  output logic                         chip_select_n,
  output logic                         power_down_select,
  output logic                         out_enable_n,
  output logic                         write_strobe_n,
  output logic                         lower_lane_enable_n,
  output logic                         upper_lane_enable_n,
  input  wire logic [`PSC_DATA_W-1:0]  data_lines_i,
  output logic [`PSC_DATA_W-1:0]       data_lines_o,
  output logic                         data_lines_oe
);
  localparam int CW = 24;
  localparam logic [CW-1:0] RC_C  = CW'(`PSC_RC_CYC);
  localparam logic [CW-1:0] WC_C  = CW'(`PSC_WC_CYC);
  localparam logic [CW-1:0] WP_C  = CW'(`PSC_WP_CYC);
  localparam logic [CW-1:0] PC_C  = CW'(`PSC_PC_CYC);
  localparam logic [CW-1:0] HZ_C  = CW'(`PSC_HZ_CYC);
  localparam logic [CW-1:0] CHP_C = CW'(CHP_CYC);
  localparam logic [CW-1:0] DPD_C = CW'(DPD_CYC);
  localparam logic [CW-1:0] CH_C  = CW'(CH_CYC);
  // two flops for read data: the pins are outside our timing
  localparam int SYNC = 2;

  psc_pkg::psc_state_t  st_q, st_d;
  logic [CW-1:0]        cnt_q, cnt_d;
  logic [`PSC_ADDR_W-1:0] addr_q, addr_d;
  logic [`PSC_DATA_W-1:0] wdat_q, wdat_d;
  logic [1:0]           lanes_q, lanes_d;
  logic                 page_q, page_d;
  logic                 lost_q, lost_d;
  logic                 rsp_q, rsp_d;
  logic [`PSC_DATA_W-1:0] rdat_q, rdat_d;
  logic [`PSC_DATA_W-1:0] sync1_q, sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser for the data lines
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= data_lines_i;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // end of a read, and a same-page follow-on offered through req_ready there
  logic rd_done, page_ok;
  assign rd_done = (st_q == psc_pkg::PSC_READ) &&
                   (cnt_q >= (page_q ? PC_C : RC_C) + CW'(SYNC) - CW'(1));
  assign page_ok = rd_done && !req_write && req_page && !dpd_req &&
                   (req_addr[`PSC_ADDR_W-1:`PSC_PAGE_W] ==
                    addr_q[`PSC_ADDR_W-1:`PSC_PAGE_W]);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q + CW'(1);
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    lanes_d = lanes_q;
    page_d  = page_q;
    lost_d  = lost_q;
    rsp_d   = 1'b0;
    rdat_d  = rdat_q;
    unique case (st_q)
      psc_pkg::PSC_POWERUP: begin
        if (cnt_q >= CHP_C - CW'(1)) begin
          st_d  = psc_pkg::PSC_IDLE;
          cnt_d = '0;
        end
      end
      psc_pkg::PSC_IDLE: begin
        cnt_d = '0;
        if (dpd_req) begin
          st_d   = psc_pkg::PSC_DPD;
          lost_d = 1'b1;
        end else if (req_valid) begin
          addr_d  = req_addr;
          wdat_d  = req_wdata;
          lanes_d = req_lanes;
          page_d  = 1'b0; // first word of a page pays the full cycle
          lost_d  = 1'b0;
          st_d    = req_write ? psc_pkg::PSC_WRITE : psc_pkg::PSC_READ;
        end
      end
      psc_pkg::PSC_READ: begin
        // a full read cycle time, or a page cycle time within an open page, each plus the two synchroniser cycles
        if (rd_done) begin
          rdat_d = sync2_q;
          rsp_d  = 1'b1;
          cnt_d  = '0;
          // next page word only if the upper address matches
          if (req_valid && page_ok) begin
            addr_d  = req_addr;
            lanes_d = req_lanes;
            page_d  = 1'b1;
          end else begin
            st_d = psc_pkg::PSC_RECOVER;
          end
        end
      end
      psc_pkg::PSC_WRITE: begin
        // strobe low for the pulse, cycle stretched to write cycle time
        if (cnt_q >= WC_C - CW'(1)) begin
          st_d  = psc_pkg::PSC_RECOVER;
          cnt_d = '0;
          rsp_d = 1'b1;
        end
      end
      psc_pkg::PSC_RECOVER: begin
        if (cnt_q >= HZ_C - CW'(1)) begin
          st_d  = psc_pkg::PSC_IDLE;
          cnt_d = '0;
        end
      end
      psc_pkg::PSC_DPD: begin
        if (cnt_q >= DPD_C - CW'(1)) begin
          cnt_d = cnt_q;
          if (wake_req) begin
            st_d  = psc_pkg::PSC_WAKE;
            cnt_d = '0;
          end
        end
      end
      psc_pkg::PSC_WAKE: begin
        if (cnt_q >= CH_C - CW'(1)) begin
          st_d  = psc_pkg::PSC_IDLE;
          cnt_d = '0;
        end
      end
      default: begin
        st_d  = psc_pkg::PSC_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q    <= psc_pkg::PSC_POWERUP;
      cnt_q   <= '0;
      addr_q  <= '0;
      wdat_q  <= '0;
      lanes_q <= 2'h0;
      page_q  <= 1'b0;
      lost_q  <= 1'b1;
      rsp_q   <= 1'b0;
      rdat_q  <= '0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      lanes_q <= lanes_d;
      page_q  <= page_d;
      lost_q  <= lost_d;
      rsp_q   <= rsp_d;
      rdat_q  <= rdat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, decoded from registered state only
  logic in_rd, in_wr;
  assign in_rd = (st_q == psc_pkg::PSC_READ);
  assign in_wr = (st_q == psc_pkg::PSC_WRITE);
  assign chip_select_n       = ~(in_rd | in_wr);
  assign power_down_select   = (st_q != psc_pkg::PSC_DPD);
  assign out_enable_n        = ~in_rd;
  // strobe falls with select and rises before it, strobe-framed write
  assign write_strobe_n      = ~(in_wr && cnt_q < WP_C);
  assign lower_lane_enable_n = ~((in_rd | in_wr) & lanes_q[0]);
  assign upper_lane_enable_n = ~((in_rd | in_wr) & lanes_q[1]);
  assign word_address        = addr_q;
  // data held on the bus through the whole write, released for reads
  assign data_lines_o        = wdat_q;
  assign data_lines_oe       = in_wr;
  // a page follow-on is a handshake too, so it is never taken unseen
  assign req_ready           = ((st_q == psc_pkg::PSC_IDLE) & ~dpd_req) | page_ok;
  assign rsp_valid           = rsp_q;
  assign rsp_rdata           = rdat_q;
  assign data_lost           = lost_q;
  assign in_dpd              = (st_q == psc_pkg::PSC_DPD);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence wr_pulse_s;
    !write_strobe_n [*5];
  endsequence

  rd_no_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
    !out_enable_n |-> !data_lines_oe && write_strobe_n)
    else $error("bus driven during read");
  wr_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(write_strobe_n) |-> wr_pulse_s ##1 write_strobe_n)
    else $error("write pulse length wrong");
  wr_framed_a: assert property (@(posedge clk) disable iff (!arst_n)
    !write_strobe_n |-> !chip_select_n && data_lines_oe)
    else $error("strobe outside select");
  wr_strobe_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(write_strobe_n) |-> !chip_select_n [*2])
    else $error("select ended before strobe");
  powerup_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    st_q == psc_pkg::PSC_POWERUP |-> chip_select_n && !req_ready)
    else $error("access during power-on hold");
  dpd_pins_a: assert property (@(posedge clk) disable iff (!arst_n)
    !power_down_select |-> chip_select_n && !data_lines_oe)
    else $error("deep standby pins wrong");
  dpd_lost_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(power_down_select) |-> data_lost)
    else $error("loss not flagged");
  page_upper_a: assert property (@(posedge clk) disable iff (!arst_n)
    in_rd && $past(in_rd) |->
      $stable(addr_q[`PSC_ADDR_W-1:`PSC_PAGE_W]))
    else $error("upper address moved in page");
  rd_time_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(out_enable_n) |-> !out_enable_n [*8])
    else $error("read cycle too short");
endmodule : psc_ctrl
`default_nettype wire

// File: psc_map.svh
// timing and layout constants of the pseudo-static ram controller
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_CLK_MHZ        100
`define PSC_ADDR_W         22
`define PSC_DATA_W         16
`define PSC_PAGE_W         3
`define PSC_RC_NS          70
`define PSC_WC_NS          70
`define PSC_WP_NS          50
`define PSC_PC_NS          30
`define PSC_OE_NS          25
`define PSC_HZ_NS          20
`define PSC_CHP_US         30
`define PSC_DPD_MS         10
`define PSC_CH_US          300
`define PSC_RC_CYC         ((`PSC_RC_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_WC_CYC         ((`PSC_WC_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_WP_CYC         ((`PSC_WP_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_PC_CYC         ((`PSC_PC_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_HZ_CYC         ((`PSC_HZ_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_CHP_CYC        (`PSC_CHP_US * `PSC_CLK_MHZ)
`define PSC_DPD_CYC        (`PSC_DPD_MS * 1000 * `PSC_CLK_MHZ)
`define PSC_CH_CYC         (`PSC_CH_US * `PSC_CLK_MHZ)
`endif

// File: psc_pkg.sv
// types of the pseudo-static ram controller
`default_nettype none
package psc_pkg;
  typedef enum logic [2:0] {
    PSC_POWERUP = 3'h0,
    PSC_IDLE    = 3'h1,
    PSC_READ    = 3'h2,
    PSC_WRITE   = 3'h3,
    PSC_RECOVER = 3'h4,
    PSC_DPD     = 3'h5,
    PSC_WAKE    = 3'h6
  } psc_state_t;
endpackage : psc_pkg
`default_nettype wire

// File: psc_mem_model.sv
// behavioural model of the pseudo-static ram standing on the controller's pins
`timescale 1ns/1ps
`default_nettype none
module psc_mem_model (
  input  wire logic        clk,
  input  wire logic [21:0] word_address,
  input  wire logic        chip_select_n,
  input  wire logic        power_down_select,
  input  wire logic        out_enable_n,
  input  wire logic        write_strobe_n,
  input  wire logic        lower_lane_enable_n,
  input  wire logic        upper_lane_enable_n,
  input  wire logic [15:0] ctl_data,
  input  wire logic        ctl_oe,
  output logic [15:0]      bus,
  output int               clash_count
);
  logic [15:0] mem [bit [21:0]];
  logic [15:0] rd_q;
  logic [15:0] last_q;
  logic [1:0]  drv;
  wire sel    = ~chip_select_n & power_down_select;
  wire wr_on  = sel & ~write_strobe_n;
  //////////////////////////////////////////////////////////////////////////////
  // lane drive: only a selected, enabled, non-writing read drives its lane
  assign drv[0] = sel & ~out_enable_n & write_strobe_n & ~lower_lane_enable_n;
  assign drv[1] = sel & ~out_enable_n & write_strobe_n & ~upper_lane_enable_n;
  // released lanes flip every cycle so a stale value never reads as good
  assign bus[7:0]  = ctl_oe ? ctl_data[7:0] : drv[0] ? rd_q[7:0] : ~last_q[7:0];
  assign bus[15:8] = ctl_oe ? ctl_data[15:8] : drv[1] ? rd_q[15:8] : ~last_q[15:8];
  // read data settles one cycle after the address, well inside the cycle time
  always @(posedge clk) begin
    last_q <= bus;
    rd_q <= mem.exists(word_address) ? mem[word_address] : ~last_q;
    if (ctl_oe === 1'b1 && |drv) clash_count <= clash_count + 1;
  end
  // the write lands when strobe or select ends it, whichever comes first
  always @(negedge wr_on) begin
    if (lower_lane_enable_n === 1'b0) mem[word_address][7:0] = bus[7:0];
    if (upper_lane_enable_n === 1'b0) mem[word_address][15:8] = bus[15:8];
  end
  // deep standby forgets every word
  always @(negedge power_down_select) mem.delete();
  initial clash_count = 0;
endmodule : psc_mem_model
`default_nettype wire

// File: tb_top.sv
// self-checking testbench of the pseudo-static ram controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int CHP = 10;
  logic        clk, arst_n, req_valid, req_write, req_page, dpd_req, wake_req;
  logic [21:0] req_addr, word_address, base;
  logic [15:0] req_wdata, rsp_rdata, dq_o, bus;
  logic [1:0]  req_lanes;
  logic        req_ready, rsp_valid, data_lost, in_dpd, cs_n, pds, oe_n, we_n, lb_n, ub_n, dq_oe;
  logic [31:0] nt;
  logic [31:0] notes [$];
  logic [15:0] exp_mem [bit [21:0]];
  int          n_fail, cmp_count, clash_count, cyc, i, k, seed;
  psc_ctrl #(.CHP_CYC(CHP), .DPD_CYC(10), .CH_CYC(10)) DUT (
    .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .req_page(req_page), .dpd_req(dpd_req), .wake_req(wake_req), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .data_lost(data_lost), .in_dpd(in_dpd), .word_address(word_address),
    .chip_select_n(cs_n), .power_down_select(pds), .out_enable_n(oe_n), .write_strobe_n(we_n),
    .lower_lane_enable_n(lb_n), .upper_lane_enable_n(ub_n), .data_lines_i(bus),
    .data_lines_o(dq_o), .data_lines_oe(dq_oe));
  psc_mem_model MEM (
    .clk(clk), .word_address(word_address), .chip_select_n(cs_n), .power_down_select(pds),
    .out_enable_n(oe_n), .write_strobe_n(we_n), .lower_lane_enable_n(lb_n),
    .upper_lane_enable_n(ub_n), .ctl_data(dq_o), .ctl_oe(dq_oe), .bus(bus),
    .clash_count(clash_count));
  //////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic tally_and_finish();
    $display("compared %0d, wrong %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // one request, held until ready is seen; the expectation is noted at acceptance
  task automatic xfer(input logic wr, input logic [21:0] a, input logic [15:0] d,
                      input logic [1:0] ln, input logic pg);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= ln;
    req_page <= pg;
    for (int j = 0; j < 2000; j++) begin
      #1;
      if (req_ready === 1'b1) break;
      @(posedge clk);
    end
    @(posedge clk);
    req_valid <= 1'b0;
    if (wr) begin
      if (!exp_mem.exists(a)) exp_mem[a] = 16'h0000;
      exp_mem[a] = (exp_mem[a] & ~m) | (d & m);
      notes.push_back(32'h0);
    end else notes.push_back({m, exp_mem[a] & m});
  endtask : xfer
  task automatic drain();
    for (int j = 0; j < 500 && notes.size() != 0; j++) @(posedge clk);
  endtask : drain
  // result watcher: the oldest note meets each response
  always @(negedge clk) begin
    if (arst_n === 1'b1 && rsp_valid === 1'b1) begin
      if (notes.size() == 0) chk_bit("rsp_valid", 1'b0, rsp_valid);
      else begin
        nt = notes.pop_front();
        chk_word("rsp_rdata", nt[15:0], rsp_rdata & nt[31:16]);
      end
    end
  end
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("timeout after %0d cycles", cyc);
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0; arst_n = 1'b0; req_valid = 1'b0; req_write = 1'b0; req_page = 1'b0;
    dpd_req = 1'b0; wake_req = 1'b0; req_addr = 22'h0; req_wdata = 16'h0; req_lanes = 2'h0;
    seed = $urandom(90);
    repeat (4) @(posedge clk);
    chk_bit("req_ready", 1'b0, req_ready);
    chk_bit("data_lost", 1'b1, data_lost);
    chk_bit("power_down_select", 1'b1, pds);
    arst_n <= 1'b1;
    repeat (CHP - 2) @(posedge clk);
    #1;
    chk_bit("req_ready", 1'b0, req_ready);
    chk_bit("chip_select_n", 1'b1, cs_n);
    $display("test power-up done");
    base = 22'($urandom) & 22'h3ffff8;
    for (i = 0; i < 8; i++) xfer(1'b1, base + 22'(i), 16'($urandom), 2'h3, 1'b0);
    xfer(1'b1, 22'h3fffff, 16'($urandom), 2'h3, 1'b0);
    xfer(1'b1, 22'h000000, 16'($urandom), 2'h3, 1'b0);
    for (i = 0; i < 8; i++) xfer(1'b0, base + 22'(i), 16'h0, 2'h3, 1'b1);
    xfer(1'b0, 22'h3fffff, 16'h0, 2'h3, 1'b0);
    xfer(1'b0, 22'h000000, 16'h0, 2'h3, 1'b0);
    $display("test word access done");
    for (k = 1; k < 3; k++) begin
      xfer(1'b1, base, 16'($urandom), 2'(k), 1'b0);
      xfer(1'b0, base, 16'h0, 2'h3, 1'b0);
      xfer(1'b0, base + 22'h1, 16'h0, 2'(k), 1'b0);
    end
    $display("test lanes done");
    drain();
    @(posedge clk);
    dpd_req <= 1'b1;
    for (k = 0; k < 500 && in_dpd !== 1'b1; k++) @(posedge clk);
    dpd_req <= 1'b0;
    exp_mem.delete();
    #1;
    chk_bit("power_down_select", 1'b0, pds);
    chk_bit("chip_select_n", 1'b1, cs_n);
    repeat (20) @(posedge clk);
    wake_req <= 1'b1;
    for (k = 0; k < 500 && in_dpd !== 1'b0; k++) @(posedge clk);
    wake_req <= 1'b0;
    for (k = 0; k < 500 && req_ready !== 1'b1; k++) @(posedge clk);
    #1;
    chk_bit("data_lost", 1'b1, data_lost);
    xfer(1'b1, base, 16'($urandom), 2'h3, 1'b0);
    xfer(1'b0, base, 16'h0, 2'h3, 1'b0);
    drain();
    chk_bit("data_lost", 1'b0, data_lost);
    $display("test deep standby done");
    chk_word("contention", 16'h0, 16'(clash_count));
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
